// ===== logic/touch_seq_pkg.sv
/*
 * constants, register map and carrier types of the touch sequencer.
 * assumes a 40 MHz REF_CLK and a 32-bit classic wishbone register bus.
 */
// Notes on behaviour
// RL1 - panel type bit selects four- or five-electrode biasing and sensing
// RL2 - four-electrode Y: drive Y sheet, convert voltage on X+
// RL3 - four-electrode X: drive X sheet, convert voltage from top sheet
// RL4 - each result is a 12-bit unsigned ratiometric code, full scale 4095
// RL5 - five-electrode X/Y: bias opposite corner pairs, convert the wiper
// RL6 - z1 and z2 pressure channels exist in four-electrode mode only
// RL7 - only raw z1/z2 codes reported; host computes contact resistance
// RL8 - host programs settle delay near ten panel RC time constants
// RL9 - wait programmed settle delay after biasing before converting
// RL10 - pen detection bias lasts one eighth of the settle delay
// RL11 - four-electrode detect: pull X+ up, ground Y-, low X+ means touch
// RL12 - five-electrode detect: pull-up on X+/corner, ground through wiper
// RL13 - pen pull-up resistance selectable among four settings
// RL14 - detected touch sets touch flag and may raise masked interrupt
// RL15 - detected release clears touch flag and may raise masked interrupt
// RL16 - detect mode only interrupts; trigger mode starts acquisition on touch
// RL17 - proximity sensing suspended while touched, resumed on release
// RL18 - manual convert: bias, wait, convert, then remove bias
// RL19 - after reset the sequencer is in manual mode
// RL20 - touch flag holds and changes only when a detection differs
package touch_seq_pkg;

  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_DELAY = 8'h04;
  localparam logic [7:0] ADR_CMD = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0C;
  localparam logic [7:0] ADR_MASK = 8'h10;
  localparam logic [7:0] ADR_RES_X = 8'h20;
  localparam logic [7:0] ADR_RES_Z2 = 8'h2C;

  // control register fields
  localparam int CTRL_PANEL_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_PULL_LSB = 3;

  // status and mask bit positions
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int EV_TOUCH_BIT = 2;
  localparam int EV_RELEASE_BIT = 3;
  localparam int EV_DONE_BIT = 4;

  // command register fields
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_CHAN_LSB = 1;

  // values after reset, and the pen bias shift
  localparam logic [15:0] DELAY_RST = 16'h0100;
  localparam logic [1:0] PULL_RST = 2'h3;
  localparam int PEN_SHIFT = 3;

  // electrode indices; five-electrode corners share the same pins
  localparam int EL_XP = 0; // also corner_bottom_right
  localparam int EL_XM = 1; // also top left corner
  localparam int EL_YP = 2; // also top right corner
  localparam int EL_YM = 3; // also bottom left corner
  localparam int EL_WIPER = 4;

  typedef enum logic [1:0] {
    MODE_MANUAL = 2'h0,
    MODE_DETECT = 2'h1,
    MODE_TRIGGER = 2'h2
  } op_mode_t;

  typedef enum logic [1:0] {
    CH_X = 2'h0,
    CH_Y = 2'h1,
    CH_Z1 = 2'h2,
    CH_Z2 = 2'h3
  } chan_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PEN = 5'h02,
    ST_BIAS = 5'h04,
    ST_CONV = 5'h08,
    ST_WAIT = 5'h10
  } seq_state_t;

  // drive pattern applied to the panel electrodes
  typedef struct packed {
    logic [4:0] drive_ref;
    logic [4:0] drive_gnd;
    logic [2:0] sense_sel;
    logic pullup_en;
    logic [1:0] pullup_sel;
  } panel_drive_t;

endpackage

// ===== logic/result_mem.sv
/*
 * four-word result store with registered read data.
 * assumes one writer and one reader on the same clock.
 */
`timescale 1ns/100ps
module result_mem (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [1:0] wr_addr,
  input wire logic [11:0] wr_data,
  input wire logic [1:0] rd_addr,
  output logic [11:0] rd_data
);

  logic [11:0] mem_q [4];
  logic [11:0] rd_q;

  // storage words, cleared at reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        mem_q[i] <= 12'h000;
      end
      rd_q <= 12'h000;
    end else begin
      if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_q <= mem_q[rd_addr];
    end
  end

  assign rd_data = rd_q;

endmodule

// ===== logic/touch_measure_seq.sv
/*
 * resistive panel measurement sequencer with a wishbone register file.
 * assumes an external converter with start/done handshake and a pen
 * comparator; both arrive as asynchronous pins and are synchronised.
 */
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/100ps
module touch_measure_seq (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic ADC_START,
  input wire logic ADC_DONE,
  input wire logic [11:0] ADC_DATA,
  input wire logic PEN_CMP_LOW,
  output touch_seq_pkg::panel_drive_t PANEL_DRIVE,
  output logic PROX_ENABLE,
  output logic IRQ_REQ
);

  // pin synchronisers
  logic done_s1_q, done_s2_q, done_s3_q;
  logic pen_s1_q, pen_s2_q;
  logic [11:0] data_s1_q, data_s2_q;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
      done_s3_q <= 1'b0;
      pen_s1_q <= 1'b0;
      pen_s2_q <= 1'b0;
      data_s1_q <= 12'h000;
      data_s2_q <= 12'h000;
    end else begin
      done_s1_q <= ADC_DONE;
      done_s2_q <= done_s1_q;
      done_s3_q <= done_s2_q;
      pen_s1_q <= PEN_CMP_LOW;
      pen_s2_q <= pen_s1_q;
      data_s1_q <= ADC_DATA;
      data_s2_q <= data_s1_q;
    end
  end

  logic adc_done_rise;
  assign adc_done_rise = done_s2_q & ~done_s3_q;

  // register state
  logic panel5_q, panel5_d;
  touch_seq_pkg::op_mode_t mode_q, mode_d;
  logic [1:0] pull_q, pull_d;
  logic [15:0] delay_q, delay_d;
  logic [2:0] mask_q, mask_d;
  logic [2:0] pend_q, pend_d;
  logic flag_q, flag_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic res_sel_q, res_sel_d;

  // sequencer state
  touch_seq_pkg::seq_state_t st_q, st_d;
  touch_seq_pkg::chan_t ch_q, ch_d;
  logic [15:0] cnt_q, cnt_d;
  logic auto_q, auto_d;
  logic start_q, start_d;

  logic bus_req, wr_stb, is_res;
  logic [31:0] wmask, cur, merged;
  logic cmd_go;
  touch_seq_pkg::chan_t cmd_ch;
  logic ev_touch, ev_release, ev_done;
  logic mem_we;
  logic [11:0] mem_rd;
  logic [15:0] pen_dly;

  assign bus_req = WB_CYC_I & WB_STB_I;
  assign wr_stb = bus_req & WB_WE_I & ack_q;
  assign is_res = (WB_ADR_I >= touch_seq_pkg::ADR_RES_X) &&
                  (WB_ADR_I <= touch_seq_pkg::ADR_RES_Z2) &&
                  (WB_ADR_I[1:0] == 2'h0);
  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                  {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign merged = (cur & ~wmask) | (WB_DAT_I & wmask);
  assign cmd_go = wr_stb && (WB_ADR_I == touch_seq_pkg::ADR_CMD) &&
                  WB_SEL_I[0] && WB_DAT_I[touch_seq_pkg::CMD_GO_BIT];
  assign cmd_ch = touch_seq_pkg::chan_t'(
                  WB_DAT_I[touch_seq_pkg::CMD_CHAN_LSB +: 2]);

  // pen bias time is an eighth of the settle delay, never zero
  assign pen_dly = ((delay_q >> touch_seq_pkg::PEN_SHIFT) == 16'h0000) ?
                   16'h0001 : (delay_q >> touch_seq_pkg::PEN_SHIFT); // [RL10]

  // current value of the addressed register, before byte merge
  always_comb begin
    cur = 32'h0000_0000;
    unique case (WB_ADR_I)
      touch_seq_pkg::ADR_CTRL: begin
        cur[touch_seq_pkg::CTRL_PANEL_BIT] = panel5_q;
        cur[touch_seq_pkg::CTRL_MODE_LSB +: 2] = mode_q;
        cur[touch_seq_pkg::CTRL_PULL_LSB +: 2] = pull_q;
      end
      touch_seq_pkg::ADR_DELAY: cur[15:0] = delay_q;
      touch_seq_pkg::ADR_STAT: begin
        cur[touch_seq_pkg::STAT_FLAG_BIT] = flag_q;
        cur[touch_seq_pkg::STAT_BUSY_BIT] = (st_q != touch_seq_pkg::ST_IDLE);
        cur[touch_seq_pkg::EV_TOUCH_BIT +: 3] = pend_q;
      end
      touch_seq_pkg::ADR_MASK: cur[touch_seq_pkg::EV_TOUCH_BIT +: 3] = mask_q;
      default: cur = 32'h0000_0000;
    endcase
  end

  // bus slave and register file next values
  always_comb begin
    ack_d = bus_req & ~ack_q;
    rdat_d = rdat_q;
    res_sel_d = res_sel_q;
    panel5_d = panel5_q;
    mode_d = mode_q;
    pull_d = pull_q;
    delay_d = delay_q;
    mask_d = mask_q;
    pend_d = pend_q;
    if (bus_req & ~ack_q) begin
      rdat_d = cur;
      res_sel_d = is_res;
    end
    if (wr_stb) begin
      unique case (WB_ADR_I)
        touch_seq_pkg::ADR_CTRL: begin
          panel5_d = merged[touch_seq_pkg::CTRL_PANEL_BIT]; // [RL1]
          if (merged[touch_seq_pkg::CTRL_MODE_LSB +: 2] != 2'h3) begin
            mode_d = touch_seq_pkg::op_mode_t'(
                     merged[touch_seq_pkg::CTRL_MODE_LSB +: 2]);
          end
          pull_d = merged[touch_seq_pkg::CTRL_PULL_LSB +: 2]; // [RL13]
        end
        touch_seq_pkg::ADR_DELAY: delay_d = merged[15:0]; // [RL8]
        touch_seq_pkg::ADR_MASK:
          mask_d = merged[touch_seq_pkg::EV_TOUCH_BIT +: 3];
        touch_seq_pkg::ADR_STAT:
          pend_d = pend_q & ~(WB_DAT_I[touch_seq_pkg::EV_TOUCH_BIT +: 3] &
                              wmask[touch_seq_pkg::EV_TOUCH_BIT +: 3]);
        default: pend_d = pend_q;
      endcase
    end
    // events set after the clear so a same-cycle event wins
    if (ev_touch) pend_d[0] = 1'b1; // [RL14]
    if (ev_release) pend_d[1] = 1'b1; // [RL15]
    if (ev_done) pend_d[2] = 1'b1;
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      res_sel_q <= 1'b0;
      panel5_q <= 1'b0;
      mode_q <= touch_seq_pkg::MODE_MANUAL; // [RL19]
      pull_q <= touch_seq_pkg::PULL_RST;
      delay_q <= touch_seq_pkg::DELAY_RST;
      mask_q <= 3'h0;
      pend_q <= 3'h0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      res_sel_q <= res_sel_d;
      panel5_q <= panel5_d;
      mode_q <= mode_d;
      pull_q <= pull_d;
      delay_q <= delay_d;
      mask_q <= mask_d;
      pend_q <= pend_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = res_sel_q ? {20'h00000, mem_rd} : rdat_q; // [RL7]
  assign IRQ_REQ = |(pend_q & mask_q); // [RL14] [RL15]
  assign PROX_ENABLE = ~flag_q; // [RL17]

  // measurement sequencer next state
  always_comb begin
    st_d = st_q;
    ch_d = ch_q;
    cnt_d = cnt_q;
    auto_d = auto_q;
    flag_d = flag_q;
    start_d = 1'b0;
    ev_touch = 1'b0;
    ev_release = 1'b0;
    ev_done = 1'b0;
    mem_we = 1'b0;
    unique case (st_q)
      touch_seq_pkg::ST_IDLE: begin
        if (mode_q == touch_seq_pkg::MODE_MANUAL) begin
          // z channels have no meaning on a five-electrode panel
          if (cmd_go && !(panel5_q && cmd_ch[1])) begin // [RL6]
            ch_d = cmd_ch;
            auto_d = 1'b0;
            cnt_d = delay_q;
            st_d = touch_seq_pkg::ST_BIAS; // [RL18]
          end
        end else begin
          cnt_d = pen_dly;
          st_d = touch_seq_pkg::ST_PEN;
        end
      end
      touch_seq_pkg::ST_PEN: begin
        if (cnt_q > 16'h0001) begin
          cnt_d = cnt_q - 16'h0001; // [RL10]
        end else begin
          st_d = touch_seq_pkg::ST_IDLE;
          if (pen_s2_q != flag_q) begin // [RL20]
            flag_d = pen_s2_q;
            ev_touch = pen_s2_q; // [RL14]
            ev_release = ~pen_s2_q; // [RL15]
          end
          // acquisition only in trigger mode with a touch present
          if (mode_q == touch_seq_pkg::MODE_TRIGGER && pen_s2_q) begin
            ch_d = touch_seq_pkg::CH_X; // [RL16]
            auto_d = 1'b1;
            cnt_d = delay_q;
            st_d = touch_seq_pkg::ST_BIAS;
          end
        end
      end
      touch_seq_pkg::ST_BIAS: begin
        if (cnt_q > 16'h0001) begin
          cnt_d = cnt_q - 16'h0001; // [RL9]
        end else begin
          start_d = 1'b1;
          st_d = touch_seq_pkg::ST_CONV;
        end
      end
      touch_seq_pkg::ST_CONV: begin
        start_d = 1'b1;
        if (adc_done_rise) begin
          st_d = touch_seq_pkg::ST_WAIT;
        end
      end
      touch_seq_pkg::ST_WAIT: begin
        if (!done_s2_q) begin
          mem_we = 1'b1; // [RL4]
          st_d = touch_seq_pkg::ST_IDLE; // [RL18]
          if (auto_q &&
              ch_q != (panel5_q ? touch_seq_pkg::CH_Y
                                : touch_seq_pkg::CH_Z2)) begin
            ch_d = touch_seq_pkg::chan_t'(ch_q + 2'h1); // [RL6]
            cnt_d = delay_q;
            st_d = touch_seq_pkg::ST_BIAS;
          end else begin
            ev_done = 1'b1;
          end
        end
      end
      default: st_d = touch_seq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_q <= touch_seq_pkg::ST_IDLE;
      ch_q <= touch_seq_pkg::CH_X;
      cnt_q <= 16'h0000;
      auto_q <= 1'b0;
      flag_q <= 1'b0;
      start_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ch_q <= ch_d;
      cnt_q <= cnt_d;
      auto_q <= auto_d;
      flag_q <= flag_d;
      start_q <= start_d;
    end
  end

  assign ADC_START = start_q;

  // electrode pattern from state, channel and panel type
  touch_seq_pkg::panel_drive_t drv;
  always_comb begin
    drv = '0;
    drv.pullup_sel = pull_q; // [RL13]
    if (st_q == touch_seq_pkg::ST_PEN) begin
      drv.pullup_en = 1'b1;
      drv.sense_sel = 3'(touch_seq_pkg::EL_XP);
      if (panel5_q) begin
        drv.drive_gnd[touch_seq_pkg::EL_WIPER] = 1'b1; // [RL12]
      end else begin
        drv.drive_gnd[touch_seq_pkg::EL_YM] = 1'b1; // [RL11]
      end
    end else if (st_q != touch_seq_pkg::ST_IDLE) begin
      if (panel5_q) begin
        drv.sense_sel = 3'(touch_seq_pkg::EL_WIPER); // [RL5]
        if (ch_q == touch_seq_pkg::CH_X) begin
          drv.drive_ref[touch_seq_pkg::EL_YP] = 1'b1;
          drv.drive_ref[touch_seq_pkg::EL_XP] = 1'b1;
          drv.drive_gnd[touch_seq_pkg::EL_XM] = 1'b1;
          drv.drive_gnd[touch_seq_pkg::EL_YM] = 1'b1;
        end else begin
          drv.drive_ref[touch_seq_pkg::EL_XM] = 1'b1;
          drv.drive_ref[touch_seq_pkg::EL_YP] = 1'b1;
          drv.drive_gnd[touch_seq_pkg::EL_YM] = 1'b1;
          drv.drive_gnd[touch_seq_pkg::EL_XP] = 1'b1;
        end
      end else begin
        unique case (ch_q)
          touch_seq_pkg::CH_X: begin
            drv.drive_ref[touch_seq_pkg::EL_XP] = 1'b1; // [RL3]
            drv.drive_gnd[touch_seq_pkg::EL_XM] = 1'b1;
            drv.sense_sel = 3'(touch_seq_pkg::EL_YP);
          end
          touch_seq_pkg::CH_Y: begin
            drv.drive_ref[touch_seq_pkg::EL_YP] = 1'b1; // [RL2]
            drv.drive_gnd[touch_seq_pkg::EL_YM] = 1'b1;
            drv.sense_sel = 3'(touch_seq_pkg::EL_XP);
          end
          touch_seq_pkg::CH_Z1: begin
            drv.drive_ref[touch_seq_pkg::EL_YP] = 1'b1; // [RL6]
            drv.drive_gnd[touch_seq_pkg::EL_XM] = 1'b1;
            drv.sense_sel = 3'(touch_seq_pkg::EL_XP);
          end
          touch_seq_pkg::CH_Z2: begin
            drv.drive_ref[touch_seq_pkg::EL_YP] = 1'b1; // [RL6]
            drv.drive_gnd[touch_seq_pkg::EL_XM] = 1'b1;
            drv.sense_sel = 3'(touch_seq_pkg::EL_YM);
          end
        endcase
      end
    end
  end

  assign PANEL_DRIVE = drv;

  // channel results, one 12-bit word per channel
  result_mem u_results (
    .clk(REF_CLK),
    .rst_n(RST_N),
    .wr_en(mem_we),
    .wr_addr(ch_q),
    .wr_data(data_s2_q),
    .rd_addr(WB_ADR_I[3:2]),
    .rd_data(mem_rd)
  );

endmodule

// ===== bench/touch_measure_seq_chk.sv
/*
 * port checker of the touch sequencer.
 * assumes it is bound to touch_measure_seq on one clock domain.
 */
`timescale 1ns/100ps
module touch_measure_seq_chk (
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic ADC_START,
  input wire logic ADC_DONE,
  input wire logic [11:0] ADC_DATA,
  input wire logic PEN_CMP_LOW,
  input wire touch_seq_pkg::panel_drive_t PANEL_DRIVE,
  input wire logic PROX_ENABLE,
  input wire logic IRQ_REQ
);
  logic [15:0] dly_q;
  logic five_q;
  logic [1:0] mode_q;
  logic [1:0] pull_q;
  logic [16:0] bcnt_q;
  logic [16:0] pcnt_q;
  logic [16:0] dly;
  logic [16:0] pmin;
  logic wr_ok;
  logic bias_on;
  logic pen_on;
  touch_seq_pkg::panel_drive_t drv_q;
  // settings seen on the bus and the settle counters
  assign wr_ok = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;
  assign pen_on = PANEL_DRIVE.pullup_en;
  assign bias_on = (|PANEL_DRIVE.drive_ref) & ~pen_on;
  assign dly = {1'b0, dly_q};
  assign pmin = (dly_q < 16'h0010) ? 17'h00001 : {4'h0, dly_q[15:3]};
  // shadow registers follow writes at the ack edge
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dly_q <= touch_seq_pkg::DELAY_RST;
      five_q <= 1'b0;
      mode_q <= 2'h0;
      pull_q <= touch_seq_pkg::PULL_RST;
      bcnt_q <= 17'h00000;
      pcnt_q <= 17'h00000;
      drv_q <= '0;
    end else begin
      drv_q <= PANEL_DRIVE;
      // restart on a new channel pattern
      bcnt_q <= (bias_on && !ADC_START) ?
        ((PANEL_DRIVE != drv_q) ? 17'h00001 : bcnt_q + 17'h00001) :
        17'h00000;
      pcnt_q <= pen_on ? pcnt_q + 17'h00001 : 17'h00000;
      if (wr_ok && WB_ADR_I == 8'h04) begin
        if (WB_SEL_I[0]) dly_q[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) dly_q[15:8] <= WB_DAT_I[15:8];
      end
      if (wr_ok && WB_ADR_I == 8'h00 && WB_SEL_I[0]) begin
        five_q <= WB_DAT_I[0];
        pull_q <= WB_DAT_I[4:3];
        if (WB_DAT_I[2:1] != 2'h3) mode_q <= WB_DAT_I[2:1];
      end
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  a_ack_after_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
    |=> WB_ACK_O) else $error("ack missing after request");
  a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  a_settle_wait: assert property ($rose(ADC_START) |->
    bcnt_q + 17'h00001 >= dly && bcnt_q <= dly + 17'h00002)
    else $error("conversion start not one settle delay after bias");
  a_start_biased: assert property (ADC_START |-> bias_on)
    else $error("conversion without channel bias");
  a_bias_removed: assert property ($fell(ADC_DONE) && mode_q == 2'h0
    |-> ##[1:4] PANEL_DRIVE.drive_ref == 5'h00)
    else $error("bias kept after conversion");
  a_pen_settle: assert property ($fell(pen_on) |->
    pcnt_q + 17'h00001 >= pmin) else $error("pen bias too short");
  a_pen_ground: assert property (pen_on |->
    PANEL_DRIVE.drive_gnd[five_q ? 4 : 3])
    else $error("pen detect return path not grounded");
  a_pull_select: assert property (pen_on |->
    PANEL_DRIVE.pullup_sel == pull_q) else $error("wrong pull-up setting");
  a_prox_follows: assert property ($changed(PROX_ENABLE) |->
    $past(pen_on) || $past(pen_on, 2) || $past(pen_on, 3))
    else $error("proximity enable moved without a pen evaluation");
  a_detect_quiet: assert property (mode_q == 2'h1 |-> !ADC_START)
    else $error("conversion in detect-only mode");
endmodule

bind touch_measure_seq touch_measure_seq_chk chk (.REF_CLK(REF_CLK),
  .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .ADC_START(ADC_START), .ADC_DONE(ADC_DONE), .ADC_DATA(ADC_DATA),
  .PEN_CMP_LOW(PEN_CMP_LOW), .PANEL_DRIVE(PANEL_DRIVE),
  .PROX_ENABLE(PROX_ENABLE), .IRQ_REQ(IRQ_REQ));

// ===== bench/panel_model.sv
/*
 * panel and converter model facing the sequencer.
 * assumes the bench sets touch state, code and answer latency.
 */
`timescale 1ns/100ps
module panel_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire touch_seq_pkg::panel_drive_t drive,
  input wire logic start,
  input wire logic touched,
  input wire logic [11:0] code,
  input wire logic [3:0] lat,
  output logic done,
  output logic [11:0] data,
  output logic pen_low
);
  logic [3:0] cnt;
  logic [2:0] hold;
  // comparator low only with pull-up on and a grounded contact path
  assign pen_low = touched & drive.pullup_en &
    (drive.drive_gnd[3] | drive.drive_gnd[4]);
  // converter answers after lat cycles, data goes stale after done
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      data <= 12'h000;
      cnt <= 4'h0;
      hold <= 3'h7;
    end else if (!done) begin
      if (hold != 3'h7) hold <= hold + 3'h1;
      if (hold == 3'h4) data <= ~data;
      if (start && cnt == lat) begin
        done <= 1'b1;
        data <= code;
        cnt <= 4'h0;
      end else if (start) cnt <= cnt + 4'h1;
      else cnt <= 4'h0;
    end else if (!start) begin
      if (cnt == 4'h3) begin
        done <= 1'b0;
        cnt <= 4'h0;
        hold <= 3'h0;
      end else cnt <= cnt + 4'h1;
    end
  end
endmodule

// ===== bench/resistive_touch_measure_seq_bench.sv
/*
 * register-level bench of the touch sequencer.
 * assumes panel_model on the far side and the bound port checker.
 */
`timescale 1ns/100ps
module resistive_touch_measure_seq_bench;
  localparam int LIM = 4000;
  logic clk, rst_n, cyc, stb, we, ack, start, done, pen_low, prox, irq;
  logic touched;
  logic [7:0] adr;
  logic [3:0] sel, lat;
  logic [31:0] wdat, rdat, q;
  logic [11:0] adata, code;
  logic [4:0] xr;
  touch_seq_pkg::panel_drive_t drive, d;
  int err_total, cmp_count, n;

  touch_measure_seq dut (.REF_CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .ADC_START(start),
    .ADC_DONE(done), .ADC_DATA(adata), .PEN_CMP_LOW(pen_low),
    .PANEL_DRIVE(drive), .PROX_ENABLE(prox), .IRQ_REQ(irq));
  panel_model far (.clk(clk), .rst_n(rst_n), .drive(drive), .start(start),
    .touched(touched), .code(code), .lat(lat), .done(done), .data(adata),
    .pen_low(pen_low));

  // 40 MHz reference clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task hang(input string nm);
    err_total++;
    $display("BAD %s expected answer seen timeout", nm);
    report_and_stop();
  endtask

  // one classic wishbone cycle, read data kept in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) hang("ack");
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask

  // manual convert: wait for start, then idle, then the stored code
  task conv(input logic [1:0] ch, input logic [11:0] c);
    code = c;
    bus(1'b1, 8'h08, {29'h0, ch, 1'b1});
    for (n = 0; n < LIM && start !== 1'b1; n++) @(negedge clk);
    if (n == LIM) hang("start");
    d = drive;
    for (n = 0; n < 200; n++) begin
      bus(1'b0, 8'h0C, 32'h0);
      if (q[1] === 1'b0) break;
    end
    if (n == 200) hang("busy");
    rdchk(8'h20 + {4'h0, ch, 2'b00}, {20'h0, c}, "result");
    chk("bias off", {27'h0, drive.drive_ref}, 32'h0);
  endtask

  task wait_prox(input logic v);
    for (n = 0; n < LIM && prox !== v; n++) @(negedge clk);
    if (n == LIM) hang("prox");
  endtask

  initial begin
    err_total = 0;
    cmp_count = 0;
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    touched = 1'b0;
    code = 12'h000;
    lat = 4'h1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    // reset values and an unmapped address
    rdchk(8'h00, 32'h18, "ctrl");
    rdchk(8'h04, 32'h100, "delay");
    rdchk(8'h0C, 32'h0, "stat");
    rdchk(8'h40, 32'h0, "unmapped");
    chk("start", {31'h0, start}, 32'h0);
    $display("test reset done");
    // four-electrode manual channels, touch held but flag untouched
    bus(1'b1, 8'h04, 32'h20);
    touched = 1'b1;
    conv(2'h0, 12'hFFF);
    chk("x pair", {27'h0, d.drive_ref | d.drive_gnd}, 32'h03);
    chk("x sense", {29'h0, d.sense_sel}, 32'h2);
    lat = 4'h9;
    conv(2'h1, 12'h800);
    chk("y pair", {27'h0, d.drive_ref | d.drive_gnd}, 32'h0C);
    chk("y sense", {29'h0, d.sense_sel}, 32'h0);
    conv(2'h2, 12'h123);
    conv(2'h3, 12'hABC);
    chk("z2 sense", {29'h0, d.sense_sel}, 32'h3);
    rdchk(8'h0C, 32'h10, "stat");
    chk("prox", {31'h0, prox}, 32'h1);
    $display("test four-electrode done");
    // five-electrode: corners and wiper, pressure refused
    bus(1'b1, 8'h00, 32'h19);
    conv(2'h0, 12'h001);
    xr = d.drive_ref;
    chk("5w sense", {29'h0, d.sense_sel}, 32'h4);
    chk("5w ref", 32'($countones(d.drive_ref)), 32'h2);
    conv(2'h1, 12'h7FE);
    chk("5w sense", {29'h0, d.sense_sel}, 32'h4);
    chk("5w dir", {31'h0, d.drive_ref != xr}, 32'h1);
    bus(1'b1, 8'h08, 32'h5);
    repeat (60) @(negedge clk);
    chk("z start", {31'h0, start}, 32'h0);
    rdchk(8'h0C, 32'h10, "z stat");
    $display("test five-electrode done");
    // five-electrode detect mode with touch and release unmasked
    bus(1'b1, 8'h0C, 32'h1C);
    bus(1'b1, 8'h10, 32'h0C);
    bus(1'b1, 8'h00, 32'h13);
    wait_prox(1'b0);
    bus(1'b0, 8'h0C, 32'h0);
    chk("touch", q & 32'h1D, 32'h05);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, 8'h0C, 32'h04);
    @(negedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    repeat (40) @(negedge clk);
    bus(1'b0, 8'h0C, 32'h0);
    chk("hold", q & 32'h1D, 32'h01);
    touched = 1'b0;
    wait_prox(1'b1);
    bus(1'b0, 8'h0C, 32'h0);
    chk("release", q & 32'h1D, 32'h08);
    chk("irq", {31'h0, irq}, 32'h1);
    bus(1'b1, 8'h10, 32'h0);
    @(negedge clk);
    chk("masked", {31'h0, irq}, 32'h0);
    $display("test detect done");
    // four-electrode trigger mode acquires all channels on touch
    bus(1'b1, 8'h0C, 32'h1C);
    code = 12'h5A5;
    bus(1'b1, 8'h00, 32'h1C);
    touched = 1'b1;
    for (n = 0; n < 400; n++) begin
      bus(1'b0, 8'h0C, 32'h0);
      if (q[4] === 1'b1) break;
    end
    if (n == 400) hang("acquire");
    chk("acquire", q & 32'h11, 32'h11);
    rdchk(8'h2C, 32'h5A5, "z2");
    touched = 1'b0;
    wait_prox(1'b1);
    bus(1'b1, 8'h00, 32'h18);
    $display("test trigger done");
    report_and_stop();
  end
endmodule
